// ===== rtl/tse_cfg.svh
`ifndef TSE_CFG_SVH
`define TSE_CFG_SVH
`define TSE_CLK_PERIOD_NS    25
`define TSE_SPROCKET_MAX_NS  20000
`define TSE_SPROCKET_CYC     (`TSE_SPROCKET_MAX_NS / `TSE_CLK_PERIOD_NS)
`define TSE_RUNAWAY_TENTHS   175
`define TSE_COUNT_SMALL_MAX  12
`define TSE_ADDR_MAX         97499
`define TSE_CHAR_ALL_ONES    6'h3F
`define TSE_PLUS_CODE        5'h07
`define TSE_INSTR_LOW        7'h2E
`define TSE_INSTR_HIGH       7'h2F
`define TSE_NUM_CODE_LO      6'h00
`define TSE_NUM_CODE_HI      6'h09
`define TSE_DIGIT_LEGAL      4'hA
`endif

// ===== rtl/tse_pkg.sv
package tse_pkg;
  typedef enum logic [3:0] {
    TSE_F46_0, TSE_F46_1, TSE_F46_2, TSE_F46_3, TSE_F46_4, TSE_F46_5, TSE_F46_6,
    TSE_F46_9, TSE_F47_2, TSE_F47_3, TSE_F47_4, TSE_F47_5, TSE_F47_7, TSE_F47_8,
    TSE_F47_9, TSE_F_NONE
  } tse_flag_t;
  localparam int TSE_NFLAGS = 15;
endpackage

// ===== rtl/tse_flag_bank.sv
module tse_flag_bank
  import tse_pkg::*;
#(
  parameter int N = TSE_NFLAGS
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flag_o
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      // set wins over a test in the same cycle
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          flag_o[g] <= 1'b0;
        end else if (set_i[g]) begin
          flag_o[g] <= 1'b1;
        end else if (clr_i[g]) begin
          flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ===== rtl/tse_error_ctrl.sv
`include "tse_cfg.svh"
module tse_error_ctrl
  import tse_pkg::*;
#(
  parameter int DW = 40,
  parameter int WCW = 5,
  parameter int CW = 16
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  t04_i,
  input  wire logic                  positioner_connected_i,
  input  wire logic                  reading_i,
  input  wire logic                  op_active_i,
  input  wire logic                  rw_error_clear_i,
  input  wire logic                  cont_instr_i,
  input  wire logic                  cont_check_set_i,
  input  wire logic                  read_mem_ended_i,
  input  wire logic                  word_count_valid_i,
  input  wire logic [WCW-1:0]        word_count_code_i,
  input  wire logic [3:0]            digit_count_i,
  input  wire logic                  mem_req_i,
  input  wire logic                  mem_xfer_done_i,
  input  wire logic                  addr_valid_i,
  input  wire logic [16:0]           addr_i,
  input  wire logic                  addr_par_i,
  input  wire logic                  data_valid_i,
  input  wire logic [DW-1:0]         data_i,
  input  wire logic                  data_par_i,
  input  wire logic                  word9_end_i,
  input  wire logic                  write_done_i,
  input  wire logic                  clutch_engaged_i,
  input  wire logic                  write_char_start_i,
  input  wire logic                  write_sprocket_pulse_i,
  input  wire logic                  out_char_valid_i,
  input  wire logic [5:0]            out_char_i,
  input  wire logic                  out_char_par_i,
  input  wire logic                  read_sprocket_i,
  input  wire logic                  skew_loaded_i,
  input  wire logic                  count_check_i,
  input  wire logic [CW-1:0]         block_count_i,
  input  wire logic [CW-1:0]         read_count_i,
  input  wire logic                  tape_moving_i,
  input  wire logic                  tenth_inch_tick_i,
  input  wire logic                  data_detect_i,
  input  wire logic                  in_char_valid_i,
  input  wire logic [5:0]            in_code_i,
  input  wire logic [4:0]            in_char_i,
  input  wire logic                  in_par_err_i,
  input  wire logic                  in_untrans_i,
  input  wire logic                  numeric_read_i,
  input  wire logic                  hash_period_gate_i,
  input  wire logic                  translate_read_gate_i,
  input  wire logic                  counter_term_one_i,
  input  wire logic                  test_strobe_i,
  input  wire logic [6:0]            test_instr_i,
  input  wire logic [3:0]            test_sel_i,
  output logic                       rw_error_o,
  output logic [TSE_NFLAGS-1:0]      diag_flags_o,
  output logic                       test_result_o,
  output logic                       cont_clear_o,
  output logic                       write_stop_o,
  output logic                       read_end_o,
  output logic [5:0]                 tape_char_o,
  output logic [4:0]                 in_buf_char_o
);
  localparam int SPK_CYC = (`TSE_SPROCKET_CYC < 1) ? 1 : `TSE_SPROCKET_CYC;

  // pins from the tape unit: clutch, write sprocket, read sprocket
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic       rd_spk_prev;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1      <= 3'h0;
      pin_s2      <= 3'h0;
      rd_spk_prev <= 1'b0;
    end else begin
      pin_s1      <= {read_sprocket_i, write_sprocket_pulse_i, clutch_engaged_i};
      pin_s2      <= pin_s1;
      rd_spk_prev <= pin_s2[2];
    end
  end
  logic clutch_ok;
  logic wr_spk;
  logic rd_spk_edge;
  assign clutch_ok   = pin_s2[0];
  assign wr_spk      = pin_s2[1];
  assign rd_spk_edge = pin_s2[2] & ~rd_spk_prev;

  // error detection
  logic continue_check_error;
  logic word_counter_parity_error;
  logic digit_counter_error_a;
  logic memory_overflow_error;
  logic memory_select_error;
  logic memory_bus_parity_error;
  logic clutch_test_error;
  logic lost_sprocket_error;
  logic output_char_parity_error;
  logic overskew_error;
  logic small_count_mismatch_error;
  logic large_count_mismatch_error;
  logic runaway_error;
  logic hash_period_parity_error;
  logic hash_period_untranslatable_error;
  logic input_char_error;
  logic untrans;
  logic req_pending;
  logic skew_pending;
  logic spk_wait;
  logic [$clog2(SPK_CYC+1)-1:0] spk_cnt;
  logic [7:0] run_cnt;
  logic [CW-1:0] diff;

  assign continue_check_error = cont_instr_i &
      (cont_check_set_i | read_mem_ended_i | ~op_active_i);
  assign word_counter_parity_error = word_count_valid_i & ~(^word_count_code_i);
  assign digit_counter_error_a = digit_count_i >= `TSE_DIGIT_LEGAL;
  assign memory_overflow_error = mem_req_i & req_pending & ~mem_xfer_done_i;
  assign memory_select_error = addr_valid_i &
      (~(^{addr_i, addr_par_i}) | (addr_i > 17'(`TSE_ADDR_MAX)));
  assign memory_bus_parity_error = data_valid_i & ~(^{data_i, data_par_i});
  assign clutch_test_error = word9_end_i & ~clutch_ok;
  assign lost_sprocket_error = spk_wait & ~wr_spk &
      (spk_cnt == ($clog2(SPK_CYC+1))'(SPK_CYC));
  assign output_char_parity_error = out_char_valid_i & ~(^{out_char_i, out_char_par_i});
  assign overskew_error = rd_spk_edge & skew_pending & ~skew_loaded_i;
  assign diff = (block_count_i > read_count_i) ? block_count_i - read_count_i
                                               : read_count_i - block_count_i;
  assign small_count_mismatch_error = count_check_i & (diff != '0) &
      (diff <= CW'(`TSE_COUNT_SMALL_MAX));
  assign large_count_mismatch_error = count_check_i &
      (diff > CW'(`TSE_COUNT_SMALL_MAX));
  assign runaway_error = tape_moving_i & tenth_inch_tick_i & ~data_detect_i &
      (run_cnt == 8'(`TSE_RUNAWAY_TENTHS - 1));
  assign untrans = in_untrans_i | (numeric_read_i & ((in_code_i < `TSE_NUM_CODE_LO) |
      (in_code_i > `TSE_NUM_CODE_HI)));
  assign hash_period_parity_error = in_char_valid_i & hash_period_gate_i & in_par_err_i;
  assign hash_period_untranslatable_error = in_char_valid_i & hash_period_gate_i & untrans;
  assign input_char_error = in_char_valid_i & ~hash_period_gate_i &
      (in_par_err_i | untrans);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_pending <= 1'b0;
    end else if (mem_req_i) begin
      req_pending <= 1'b1;
    end else if (mem_xfer_done_i) begin
      req_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skew_pending <= 1'b0;
    end else if (rd_spk_edge) begin
      skew_pending <= 1'b1;
    end else if (skew_loaded_i) begin
      skew_pending <= 1'b0;
    end
  end

  // write sprocket deadline after each character start
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spk_wait <= 1'b0;
      spk_cnt  <= '0;
    end else if (write_char_start_i) begin
      spk_wait <= 1'b1;
      spk_cnt  <= '0;
    end else if (spk_wait & (wr_spk | lost_sprocket_error)) begin
      spk_wait <= 1'b0;
    end else if (spk_wait) begin
      spk_cnt <= spk_cnt + 1'b1;
    end
  end

  // distance travelled without data, in tenths of an inch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cnt <= 8'h00;
    end else if (data_detect_i | ~tape_moving_i | runaway_error) begin
      run_cnt <= 8'h00;
    end else if (tenth_inch_tick_i) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end

  // diagnostic flag set and test
  logic [TSE_NFLAGS-1:0] flag_set;
  logic [TSE_NFLAGS-1:0] flag_clr;
  tse_flag_t             sel_flag;
  always_comb begin
    flag_set = '0;
    flag_set[TSE_F46_0] = runaway_error;
    flag_set[TSE_F46_1] = memory_bus_parity_error;
    flag_set[TSE_F46_2] = memory_select_error;
    flag_set[TSE_F46_3] = hash_period_untranslatable_error |
                          (input_char_error & untrans);
    flag_set[TSE_F46_4] = memory_overflow_error;
    flag_set[TSE_F46_5] = hash_period_parity_error |
                          (input_char_error & in_par_err_i);
    flag_set[TSE_F46_6] = output_char_parity_error;
    flag_set[TSE_F46_9] = clutch_test_error;
    flag_set[TSE_F47_2] = large_count_mismatch_error;
    flag_set[TSE_F47_3] = word_counter_parity_error;
    flag_set[TSE_F47_4] = lost_sprocket_error;
    flag_set[TSE_F47_5] = continue_check_error;
    flag_set[TSE_F47_7] = small_count_mismatch_error;
    flag_set[TSE_F47_8] = overskew_error;
    flag_set[TSE_F47_9] = digit_counter_error_a;
  end

  // instruction number plus selector digit names one flag
  always_comb begin
    sel_flag = TSE_F_NONE;
    if (test_instr_i == `TSE_INSTR_LOW) begin
      unique case (test_sel_i)
        4'h0: sel_flag = TSE_F46_0;
        4'h1: sel_flag = TSE_F46_1;
        4'h2: sel_flag = TSE_F46_2;
        4'h3: sel_flag = TSE_F46_3;
        4'h4: sel_flag = TSE_F46_4;
        4'h5: sel_flag = TSE_F46_5;
        4'h6: sel_flag = TSE_F46_6;
        4'h9: sel_flag = TSE_F46_9;
        default: sel_flag = TSE_F_NONE;
      endcase
    end else if (test_instr_i == `TSE_INSTR_HIGH) begin
      unique case (test_sel_i)
        4'h2: sel_flag = TSE_F47_2;
        4'h3: sel_flag = TSE_F47_3;
        4'h4: sel_flag = TSE_F47_4;
        4'h5: sel_flag = TSE_F47_5;
        4'h7: sel_flag = TSE_F47_7;
        4'h8: sel_flag = TSE_F47_8;
        4'h9: sel_flag = TSE_F47_9;
        default: sel_flag = TSE_F_NONE;
      endcase
    end
  end

  always_comb begin
    flag_clr = '0;
    if (test_strobe_i && sel_flag != TSE_F_NONE) begin
      flag_clr[sel_flag] = 1'b1;
    end
  end

  tse_flag_bank #(.N(TSE_NFLAGS)) u_flags (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .set_i   (flag_set),
    .clr_i   (flag_clr),
    .flag_o  (diag_flags_o)
  );

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      test_result_o <= 1'b0;
    end else if (test_strobe_i) begin
      test_result_o <= (sel_flag != TSE_F_NONE) && diag_flags_o[sel_flag];
    end
  end

  // common read-write error flag
  logic read_side_err;
  logic common_set;
  assign read_side_err = (overskew_error | small_count_mismatch_error |
      large_count_mismatch_error | runaway_error | hash_period_parity_error |
      hash_period_untranslatable_error |
      (input_char_error & hash_period_gate_i & translate_read_gate_i &
       ~counter_term_one_i & t04_i)) & ~positioner_connected_i;
  assign common_set = read_side_err | continue_check_error | word_counter_parity_error |
      digit_counter_error_a | memory_overflow_error | memory_select_error |
      memory_bus_parity_error | clutch_test_error | lost_sprocket_error |
      output_char_parity_error;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rw_error_o <= 1'b0;
    end else if (common_set) begin
      rw_error_o <= 1'b1;
    end else if (rw_error_clear_i) begin
      rw_error_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cont_clear_o <= 1'b0;
    end else begin
      cont_clear_o <= reading_i & (common_set | rw_error_o);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      write_stop_o <= 1'b0;
    end else if (clutch_test_error) begin
      write_stop_o <= 1'b1;
    end else if (write_done_i) begin
      write_stop_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_end_o <= 1'b0;
    end else begin
      read_end_o <= small_count_mismatch_error | large_count_mismatch_error |
                    runaway_error;
    end
  end

  // character substitution
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tape_char_o <= 6'h00;
    end else if (out_char_valid_i) begin
      tape_char_o <= output_char_parity_error ? `TSE_CHAR_ALL_ONES : out_char_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_buf_char_o <= 5'h00;
    end else if (in_char_valid_i) begin
      in_buf_char_o <= (input_char_error & untrans) ? `TSE_PLUS_CODE : in_char_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_cont_check_flag: assert property (continue_check_error |=> diag_flags_o[TSE_F47_5])
    else $error("continue-check flag not set");
  a_flag_hold: assert property (diag_flags_o[TSE_F46_4] && !flag_clr[TSE_F46_4]
      |=> diag_flags_o[TSE_F46_4])
    else $error("overflow flag dropped without test");
  a_test_clears: assert property (flag_clr[TSE_F47_8] && !flag_set[TSE_F47_8]
      |=> !diag_flags_o[TSE_F47_8])
    else $error("tested flag not cleared");
  a_common_error: assert property (common_set |=> rw_error_o)
    else $error("common error flag not set");
  a_all_ones_char: assert property (output_char_parity_error |=> tape_char_o == 6'h3F)
    else $error("bad output character not replaced");
  a_plus_code: assert property (input_char_error && untrans |=> in_buf_char_o == 5'h07)
    else $error("untranslatable input not replaced");
  a_read_ending: assert property ($rose(diag_flags_o[TSE_F47_2]) |-> read_end_o)
    else $error("large count mismatch did not end read");
  a_select_range: assert property (addr_valid_i && addr_i > 17'd97499
      |=> diag_flags_o[TSE_F46_2])
    else $error("address above range not flagged");
  a_clutch_stop: assert property (clutch_test_error |=> write_stop_o && diag_flags_o[TSE_F46_9])
    else $error("clutch error did not stop write");
  a_cont_clear: assert property (reading_i && common_set |=> cont_clear_o)
    else $error("continue flags not cleared on read error");
endmodule

// ===== sim/tse_cpu_model.sv
module tse_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       req_i,
  input  wire logic [6:0] instr_i,
  input  wire logic [3:0] sel_i,
  output logic            test_strobe_o,
  output logic [6:0]      test_instr_o,
  output logic [3:0]      test_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // one-cycle test strobe; released fields show the inverse of the last value
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      test_strobe_o <= 1'b0;
      test_instr_o  <= 7'h00;
      test_sel_o    <= 4'h0;
    end else if (req_i) begin
      test_strobe_o <= 1'b1;
      test_instr_o  <= instr_i;
      test_sel_o    <= sel_i;
    end else begin
      test_strobe_o <= 1'b0;
      test_instr_o  <= ~test_instr_o;
      test_sel_o    <= ~test_sel_o;
    end
  end
endmodule

// ===== sim/tb_top.sv
module tb_top;
  import tse_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, rst_b_i = 0, t04_i = 0, positioner_connected_i = 0, reading_i = 0;
  logic op_active_i = 0, rw_error_clear_i = 0, cont_instr_i = 0, cont_check_set_i = 0;
  logic read_mem_ended_i = 0, word_count_valid_i = 0, mem_req_i = 0, mem_xfer_done_i = 0;
  logic addr_valid_i = 0, addr_par_i = 0, data_valid_i = 0, data_par_i = 0, word9_end_i = 0;
  logic write_done_i = 0, clutch_engaged_i = 1, write_char_start_i = 0;
  logic write_sprocket_pulse_i = 0, out_char_valid_i = 0, out_char_par_i = 0;
  logic read_sprocket_i = 0, count_check_i = 0, tape_moving_i = 0, tenth_inch_tick_i = 0;
  logic in_char_valid_i = 0, in_par_err_i = 0, in_untrans_i = 0, numeric_read_i = 0;
  logic hash_period_gate_i = 0, translate_read_gate_i = 0, req = 0;
  logic skew_loaded_i = 0, data_detect_i = 0;
  logic test_strobe_i, test_result_o, rw_error_o, cont_clear_o, write_stop_o, read_end_o;
  logic [4:0]            word_count_code_i = '0, in_char_i = '0, in_buf_char_o;
  logic [3:0]            digit_count_i = '0, test_sel_i, sel_r = '0;
  logic [16:0]           addr_i = '0;
  logic [39:0]           data_i = '0;
  logic [5:0]            out_char_i = '0, in_code_i = '0, tape_char_o;
  logic [15:0]           block_count_i = '0, read_count_i = '0;
  logic [6:0]            test_instr_i, instr_r = '0;
  logic [TSE_NFLAGS-1:0] diag_flags_o;
  int mismatches = 0;
  int tests_run = 0;
  int sels[15] = '{0, 1, 2, 3, 4, 5, 6, 9, 2, 3, 4, 5, 7, 8, 9};

  tse_error_ctrl u_tse_error_ctrl (.mclk_i, .rst_b_i, .t04_i, .positioner_connected_i,
    .reading_i, .op_active_i, .rw_error_clear_i, .cont_instr_i, .cont_check_set_i,
    .read_mem_ended_i, .word_count_valid_i, .word_count_code_i, .digit_count_i, .mem_req_i,
    .mem_xfer_done_i, .addr_valid_i, .addr_i, .addr_par_i, .data_valid_i, .data_i,
    .data_par_i, .word9_end_i, .write_done_i, .clutch_engaged_i, .write_char_start_i,
    .write_sprocket_pulse_i, .out_char_valid_i, .out_char_i, .out_char_par_i,
    .read_sprocket_i, .skew_loaded_i, .count_check_i, .block_count_i, .read_count_i,
    .tape_moving_i, .tenth_inch_tick_i, .data_detect_i, .in_char_valid_i, .in_code_i,
    .in_char_i, .in_par_err_i, .in_untrans_i, .numeric_read_i, .hash_period_gate_i,
    .translate_read_gate_i, .counter_term_one_i(1'b0), .test_strobe_i, .test_instr_i,
    .test_sel_i, .rw_error_o, .diag_flags_o, .test_result_o, .cont_clear_o, .write_stop_o,
    .read_end_o, .tape_char_o, .in_buf_char_o);
  tse_cpu_model u_tse_cpu_model (.mclk_i, .rst_b_i, .req_i(req), .instr_i(instr_r),
    .sel_i(sel_r), .test_strobe_o(test_strobe_i), .test_instr_o(test_instr_i),
    .test_sel_o(test_sel_i));

  always #12.5 mclk_i = ~mclk_i;

  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic probe(logic [6:0] ins, logic [3:0] sel, logic exp);
    req = 1;
    instr_r = ins;
    sel_r = sel;
    step;
    req = 0;
    step;
    chk("test_result_o", {15'h0, exp}, {15'h0, test_result_o});
  endtask
  // wait for a flag, check the common flag, then test the flag away
  task automatic flag_seen(int idx, int bound, logic rw);
    int n;
    n = 0;
    while (diag_flags_o[idx] !== 1'b1 && n < bound) begin
      step;
      n++;
    end
    chk($sformatf("flag %0d", idx), 16'h1, {15'h0, diag_flags_o[idx]});
    chk("rw_error_o", {15'h0, rw}, {15'h0, rw_error_o});
    probe(idx < 8 ? 7'h2E : 7'h2F, sels[idx][3:0], 1'b1);
    chk("flag after test", 16'h0, {15'h0, diag_flags_o[idx]});
    rw_error_clear_i = 1;
    step;
    rw_error_clear_i = 0;
  endtask
  task automatic stop_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #300us;
    mismatches++;
    stop_test;
  end

  initial begin
    logic [16:0] a;
    repeat (5) @(posedge mclk_i);
    chk("outputs in reset", 16'h0, {rw_error_o, diag_flags_o});
    #1 rst_b_i = 1;
    step;
    out_char_i = 6'h03;
    out_char_valid_i = 1;
    step;
    out_char_valid_i = 0;
    chk("tape_char_o", 16'h3F, {10'h0, tape_char_o});
    flag_seen(6, 2, 1);
    probe(7'h2E, 4'h7, 0);
    out_char_i = 6'h07;
    out_char_valid_i = 1;
    step;
    out_char_valid_i = 0;
    chk("tape_char_o", 16'h07, {10'h0, tape_char_o});
    mem_req_i = 1;
    step;
    mem_req_i = 0;
    step(3);
    mem_req_i = 1;
    step;
    mem_req_i = 0;
    flag_seen(4, 2, 1);
    mem_xfer_done_i = 1;
    step;
    mem_xfer_done_i = 0;
    mem_req_i = 1;
    step;
    mem_req_i = 0;
    mem_xfer_done_i = 1;
    step;
    mem_xfer_done_i = 0;
    mem_req_i = 1;
    step;
    mem_req_i = 0;
    step;
    chk("no overflow", 16'h0, {15'h0, diag_flags_o[4]});
    reading_i = 1;
    digit_count_i = 4'hA;
    step;
    digit_count_i = 4'h9;
    step(2);
    chk("cont_clear_o", 16'h1, {15'h0, cont_clear_o});
    reading_i = 0;
    flag_seen(14, 2, 1);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 17'd97499 : (i == 1) ? 17'd97500 : 17'd5;
      addr_i = a;
      addr_par_i = (i == 2) ? ^a : ~^a;
      addr_valid_i = 1;
      step;
      addr_valid_i = 0;
      if (i == 0) begin
        step;
        chk("addr in range", 16'h0, {15'h0, diag_flags_o[2]});
      end else flag_seen(2, 2, 1);
    end
    data_i = 40'h1;
    data_par_i = 1;
    data_valid_i = 1;
    step;
    data_valid_i = 0;
    flag_seen(1, 2, 1);
    word_count_code_i = 5'h03;
    word_count_valid_i = 1;
    step;
    word_count_valid_i = 0;
    flag_seen(9, 2, 1);
    for (int i = 0; i < 4; i++) begin
      op_active_i = (i != 0);
      reading_i = (i != 0);
      read_mem_ended_i = (i == 1);
      cont_check_set_i = (i == 2);
      cont_instr_i = 1;
      step;
      cont_instr_i = 0;
      if (i < 3) flag_seen(11, 2, 1);
      else begin
        step;
        chk("cont in time", 16'h0, {15'h0, diag_flags_o[11]});
      end
    end
    {op_active_i, reading_i, read_mem_ended_i, cont_check_set_i} = '0;
    word9_end_i = 1;
    step;
    word9_end_i = 0;
    step(4);
    chk("clutch engaged", 16'h0, {diag_flags_o[7], write_stop_o});
    clutch_engaged_i = 0;
    step(3);
    word9_end_i = 1;
    step;
    word9_end_i = 0;
    flag_seen(7, 6, 1);
    chk("write_stop_o", 16'h1, {15'h0, write_stop_o});
    write_done_i = 1;
    step;
    write_done_i = 0;
    step;
    chk("write_stop_o", 16'h0, {15'h0, write_stop_o});
    write_char_start_i = 1;
    step;
    write_char_start_i = 0;
    step(50);
    write_sprocket_pulse_i = 1;
    step(3);
    write_sprocket_pulse_i = 0;
    step(800);
    chk("sprocket in time", 16'h0, {15'h0, diag_flags_o[10]});
    write_char_start_i = 1;
    step;
    write_char_start_i = 0;
    flag_seen(10, 810, 1);
    for (int p = 0; p < 2; p++) begin
      positioner_connected_i = p[0];
      repeat (2) begin
        read_sprocket_i = 1;
        step(3);
        read_sprocket_i = 0;
        step(3);
      end
      flag_seen(13, 8, !p[0]);
    end
    positioner_connected_i = 0;
    // each character loaded before the next sprocket: no overskew
    skew_loaded_i = 1;
    step;
    skew_loaded_i = 0;
    repeat (2) begin
      read_sprocket_i = 1;
      step(3);
      read_sprocket_i = 0;
      step(3);
      skew_loaded_i = 1;
      step;
      skew_loaded_i = 0;
    end
    step(3);
    chk("no overskew", 16'h0, {15'h0, diag_flags_o[13]});
    for (int d = 12; d < 14; d++) begin
      block_count_i = 16'd100;
      read_count_i = 16'(100 - d);
      count_check_i = 1;
      step;
      count_check_i = 0;
      chk("read_end_o", 16'h1, {15'h0, read_end_o});
      step;
      chk("read_end_o pulse", 16'h0, {15'h0, read_end_o});
      flag_seen(d == 12 ? 12 : 8, 2, 1);
    end
    tape_moving_i = 1;
    // data seen at tick 100 restarts the distance count
    for (int t = 0; t < 276; t++) begin
      if (t == 274) chk("no runaway", 16'h0, {15'h0, diag_flags_o[0]});
      tenth_inch_tick_i = 1;
      data_detect_i = (t == 100);
      step;
      tenth_inch_tick_i = 0;
      data_detect_i = 0;
      step;
    end
    chk("read_end_o", 16'h1, {15'h0, read_end_o | diag_flags_o[0]});
    tape_moving_i = 0;
    flag_seen(0, 3, 1);
    for (int i = 0; i < 5; i++) begin
      hash_period_gate_i = (i < 2);
      in_par_err_i = (i == 0 || i == 3);
      in_untrans_i = (i == 1);
      numeric_read_i = (i >= 2);
      {t04_i, translate_read_gate_i} = {2{i >= 2}};
      in_code_i = (i == 2) ? 6'h0C : 6'h05;
      in_char_i = in_code_i[4:0];
      in_char_valid_i = 1;
      step;
      in_char_valid_i = 0;
      if (i == 2) chk("in_buf_char_o", 16'h07, {11'h0, in_buf_char_o});
      if (i == 4) chk("in_buf_char_o", 16'h05, {11'h0, in_buf_char_o});
      if (i < 4) flag_seen((i == 0 || i == 3) ? 5 : 3, 2, i < 2);
    end
    step;
    chk("flags idle", 16'h0, {rw_error_o, diag_flags_o});
    stop_test;
  end
endmodule
